// >>> verilog/tss_switch.sv
`timescale 1ns/10ps
// time and space switch core
module tss_switch
	import tss_pkg::*;
(
	// clock and reset
	input  logic        CLK_SYS,
	input  logic        RST,
	// configuration
	input  logic [1:0]  MODE,
	input  logic        WIDE16,
	input  logic        FRAME_SYNC,
	// serial lines, mode 0
	input  logic [7:0]  SERIAL_LINE_IN,
	input  logic [7:0]  ALT_LINE_IN,
	input  logic        ALT_SEL,
	output logic [7:0]  SERIAL_LINE_OUT,
	output logic [7:0]  ALT_LINE_OUT,
	// parallel stream, modes 1 and 2
	input  logic [15:0] PAR_IN,
	input  logic        PAR_IN_VALID,
	output logic [15:0] PAR_OUT,
	output logic [9:0]  PAR_OUT_SLOT,
	output logic        PAR_OUT_VALID,
	input  logic        PAR_OUT_READY,
	// host port
	input  logic        HOST_WE,
	input  logic [1:0]  HOST_TGT,
	input  logic [9:0]  HOST_ADDR,
	input  logic [9:0]  HOST_WDATA
);
	// ==========================================
	// storage
	logic [7:0] sw_lo [2][CH_DEPTH];   // low byte planes
	logic [7:0] sw_hi [2][CH_DEPTH];   // high byte, wide mode
	logic [9:0] ctrl_mem [CH_DEPTH];   // source slot per output slot
	logic [7:0] tctrl_mem [CH_DEPTH];  // tone select per output slot
	logic [7:0] tone_mem [TONE_DEPTH];
	// counters and state
	logic [9:0]  wr_cnt_reg, wr_cnt_next;
	logic [9:0]  rd_cnt_reg, rd_cnt_next;
	logic        plane_reg, plane_next;
	logic [2:0]  bit_reg, bit_next;
	logic [7:0]  shin_reg [LINES];
	logic [7:0]  shin_next [LINES];
	logic [7:0]  shout_reg [LINES];
	logic [7:0]  shout_next [LINES];
	logic [7:0]  sout_reg, sout_next;
	logic [9:0]  last;
	logic [7:0]  line_in;
	logic        wr_go, rd_go;
	logic [9:0]  src;
	logic [7:0]  tsel;
	logic [15:0] word;
	tss_buf_if   bif ();
	logic [25:0] bdata;
	logic        bvalid;
	logic        out_take;   // output stage may load a new word
	tss_mode_t   mode;
	// ==========================================
	// frame timing
	always_comb begin
		mode = tss_mode_t'(MODE);
		line_in = ALT_SEL ? ALT_LINE_IN : SERIAL_LINE_IN;
		last = (mode == TSS_MODE1) ? LAST_M1 : LAST_M2;
		bit_next = FRAME_SYNC ? 3'h0 : bit_reg + 3'h1;
		// RL5 deserialise all eight lines
		for (int i = 0; i < LINES; i++) begin
			shin_next[i] = {shin_reg[i][6:0], line_in[i]};
		end
		// mode 0 writes eight slots per byte time via fanout
		wr_go = (mode == TSS_MODE0) ? (bit_reg == BIT_LAST)
			: PAR_IN_VALID;
		rd_go = bif.ready && ((mode != TSS_MODE0) ||
			(bit_reg == BIT_LAST));
		// RL1 write counter follows the input frame
		wr_cnt_next = wr_cnt_reg;
		if (FRAME_SYNC) begin
			wr_cnt_next = 10'h000;
		end else if (wr_go) begin
			wr_cnt_next = (mode == TSS_MODE0) ?
				wr_cnt_reg + 10'h008 :
				((wr_cnt_reg == last) ? 10'h000 : wr_cnt_reg + 10'h001);
		end
		// RL3 read counter per output slot
		rd_cnt_next = rd_cnt_reg;
		if (FRAME_SYNC) begin
			rd_cnt_next = 10'h000;
		end else if (rd_go) begin
			rd_cnt_next = (mode == TSS_MODE0) ?
				rd_cnt_reg + 10'h008 :
				((rd_cnt_reg == last) ? 10'h000 : rd_cnt_reg + 10'h001);
		end
		// RL13 swap planes at frame start
		plane_next = FRAME_SYNC ? ~plane_reg : plane_reg;
	end
	// ==========================================
	// storage writes
	always_ff @(posedge CLK_SYS) begin
		// RL12 host programs control stores
		if (HOST_WE && HOST_TGT == TGT_CTRL) begin
			ctrl_mem[HOST_ADDR] <= HOST_WDATA;
		end
		// RL11 tone control and tone stores
		if (HOST_WE && HOST_TGT == TGT_TCTRL) begin
			tctrl_mem[HOST_ADDR] <= HOST_WDATA[7:0];
		end
		if (HOST_WE && HOST_TGT == TGT_TONE) begin
			tone_mem[HOST_ADDR[5:0]] <= HOST_WDATA[7:0];
		end
		// RL1 input slot lands at its own slot number
		if (mode == TSS_MODE0 && wr_go) begin
			for (int i = 0; i < LINES; i++) begin
				sw_lo[plane_reg][tss_slot(wr_cnt_reg[9:3],
					3'(i))] <= shin_next[i];
			end
		end else if (wr_go) begin
			// RL7 RL8 parallel input written directly
			sw_lo[plane_reg][wr_cnt_reg] <= PAR_IN[7:0];
			// RL10 second plane carries the high byte
			if (WIDE16) begin
				sw_hi[plane_reg][wr_cnt_reg] <= PAR_IN[15:8];
			end
		end
	end
	// ==========================================
	// read path; mode 0 only presents the first line's slot here
	always_comb begin
		// RL2 control entry names the input slot
		src  = ctrl_mem[rd_cnt_reg];
		tsel = tctrl_mem[rd_cnt_reg];
		// RL3 RL9 read from the plane not being written
		word = {WIDE16 ? sw_hi[~plane_reg][src] : 8'h00,
			sw_lo[~plane_reg][src]};
		// RL14 tone flag overrides switched data
		if (tsel[TONE_FLAG_B]) begin
			word = {8'h00, tone_mem[tsel[5:0]]};
		end
		bif.data  = {rd_cnt_reg, word[15:8], word[7:0]};
		bif.valid = rd_go;
		// RL4 RL6 mode 0 loads every output line shifter
		for (int i = 0; i < LINES; i++) begin
			shout_next[i] = {shout_reg[i][6:0], 1'b0};
			if (mode == TSS_MODE0 && bit_reg == BIT_LAST) begin
				shout_next[i] = sw_lo[~plane_reg][
					ctrl_mem[tss_slot(rd_cnt_reg[9:3], 3'(i))]];
			end
			sout_next[i] = shout_reg[i][7];
		end
	end
	// ==========================================
	// registers
	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			wr_cnt_reg <= 10'h000;
			rd_cnt_reg <= 10'h000;
			plane_reg <= 1'b0;
			bit_reg <= 3'h0;
			sout_reg <= 8'h00;
			for (int i = 0; i < LINES; i++) begin
				shin_reg[i] <= 8'h00;
				shout_reg[i] <= 8'h00;
			end
		end else begin
			wr_cnt_reg <= wr_cnt_next;
			rd_cnt_reg <= rd_cnt_next;
			plane_reg <= plane_next;
			bit_reg <= bit_next;
			sout_reg <= sout_next;
			shin_reg <= shin_next;
			shout_reg <= shout_next;
		end
	end
	// ==========================================
	// output buffer
	tss_skid u_buf (
		.clk       (CLK_SYS),
		.rst       (RST),
		.in_s      (bif),
		.out_data  (bdata),
		.out_valid (bvalid),
		.out_ready (out_take)
	);
	// the output register only drains the buffer when its own word
	// has gone, so a receiver stall never drops a word
	assign out_take = ~PAR_OUT_VALID | PAR_OUT_READY;
	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			PAR_OUT <= 16'h0000;
			PAR_OUT_SLOT <= 10'h000;
			PAR_OUT_VALID <= 1'b0;
		end else if (out_take) begin
			PAR_OUT <= bdata[15:0];
			PAR_OUT_SLOT <= bdata[25:16];
			PAR_OUT_VALID <= bvalid;
		end
	end
	assign SERIAL_LINE_OUT = sout_reg;
	assign ALT_LINE_OUT = sout_reg;
	// ==========================================
	// RL13
	plane_swap_a: assert property (@(posedge CLK_SYS) disable iff (RST)
		FRAME_SYNC |=> plane_reg != $past(plane_reg))
		else $error("plane did not swap");
	// RL1
	wr_restart_a: assert property (@(posedge CLK_SYS) disable iff (RST)
		FRAME_SYNC |=> wr_cnt_reg == 10'h000)
		else $error("write counter not restarted");
	// RL3
	rd_restart_a: assert property (@(posedge CLK_SYS) disable iff (RST)
		FRAME_SYNC |=> rd_cnt_reg == 10'h000)
		else $error("read counter not restarted");
	// RL3 parallel read wraps at frame end
	rd_wrap_a: assert property (@(posedge CLK_SYS) disable iff (RST)
		(mode != TSS_MODE0 && rd_go && rd_cnt_reg == last && !FRAME_SYNC)
		|=> rd_cnt_reg == 10'h000)
		else $error("read counter did not wrap");
	// RL12
	host_ctrl_a: assert property (@(posedge CLK_SYS) disable iff (RST)
		(HOST_WE && HOST_TGT == TGT_CTRL) |=>
		ctrl_mem[$past(HOST_ADDR)] == $past(HOST_WDATA))
		else $error("control entry not written");
	// RL3 stalled output word must stand
	sequence out_stall_s;
		PAR_OUT_VALID && !PAR_OUT_READY;
	endsequence
	out_hold_a: assert property (@(posedge CLK_SYS) disable iff (RST)
		out_stall_s |=> PAR_OUT_VALID && $stable(PAR_OUT))
		else $error("stalled output word changed");
endmodule : tss_switch

// >>> verilog/tss_pkg.sv
// Notes on behaviour
// RL1: write counter addresses storage by input slot
// RL2: control entry per output slot holds source
// RL3: read counter, control lookup, then storage read
// RL4: serial mode shifts output bytes onto lines
// RL5: mode 0 deserialises and multiplexes eight lines
// RL6: mode 0 routes any line slot anywhere
// RL7: mode 1 switches 512 parallel channels
// RL8: mode 2 switches 1024 parallel channels
// RL9: two 1K x 8 planes, 1K x 10 control
// RL10: paired planes give 16-bit width option
// RL11: 64-word tone store, 1K tone control
// RL12: host writes control and tone control stores
// RL13: storage planes swap every frame
// RL14: tone flag picks tone over switched data; the mode 0 serial line outputs ignore it and carry switched data
package tss_pkg;
	// ==========================================
	// sizes
	localparam int CH_W        = 10;
	localparam int DATA_W      = 8;
	localparam int TONE_AW     = 6;
	localparam int TONE_DEPTH  = 64;
	localparam int CH_DEPTH    = 1024;
	localparam int LINES       = 8;
	localparam int LINE_CH_W   = 7;
	localparam int TONE_FLAG_B = 7;
	// ==========================================
	// host write targets
	localparam logic [1:0] TGT_CTRL  = 2'h0;
	localparam logic [1:0] TGT_TCTRL = 2'h1;
	localparam logic [1:0] TGT_TONE  = 2'h2;
	// ==========================================
	// frame lengths minus one per mode
	localparam logic [9:0] LAST_M0 = 10'h3ff;
	localparam logic [9:0] LAST_M1 = 10'h1ff;
	localparam logic [9:0] LAST_M2 = 10'h3ff;
	localparam logic [2:0] BIT_LAST = 3'h7;
	// ==========================================
	// operating modes
	typedef enum logic [1:0] {
		TSS_MODE0 = 2'b00,
		TSS_MODE1 = 2'b01,
		TSS_MODE2 = 2'b10
	} tss_mode_t;
	// mode 0 slot index: channel in high bits, line in low bits
	function automatic logic [9:0] tss_slot(input logic [6:0] ch,
		input logic [2:0] ln);
		tss_slot = {ch, ln};
	endfunction : tss_slot
endpackage : tss_pkg

// >>> verilog/tss_buf_if.sv
`timescale 1ns/10ps
// output word stream between switch core and buffer
interface tss_buf_if;
	logic [25:0] data;   // {slot, high byte, low byte}
	logic        valid;
	logic        ready;
	modport src (output data, output valid, input ready);
	modport dst (input data, input valid, output ready);
endinterface : tss_buf_if

// >>> verilog/tss_skid.sv
`timescale 1ns/10ps
// two-entry buffer; a stall downstream loses no word
module tss_skid
	import tss_pkg::*;
(
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// filling side
	tss_buf_if.dst           in_s,
	// draining side
	output logic [25:0]      out_data,
	output logic             out_valid,
	input  wire logic        out_ready
);
	logic [25:0] mem_reg [2];   // two entries
	logic [25:0] mem_next [2];
	logic        wp_reg, wp_next, rp_reg, rp_next;
	logic [1:0]  cnt_reg, cnt_next;
	logic        push, pop;
	// ==========================================
	// next-state
	always_comb begin
		push = in_s.valid && (cnt_reg != 2'h2);
		pop  = (cnt_reg != 2'h0) && out_ready;
		mem_next = mem_reg;
		wp_next = wp_reg;
		rp_next = rp_reg;
		cnt_next = cnt_reg;
		if (push) begin
			mem_next[wp_reg] = in_s.data;
			wp_next = ~wp_reg;
		end
		if (pop) begin
			rp_next = ~rp_reg;
		end
		cnt_next = cnt_reg + {1'b0, push} - {1'b0, pop};
	end
	// registers
	always_ff @(posedge clk) begin
		if (rst) begin
			mem_reg[0] <= 26'h0;
			mem_reg[1] <= 26'h0;
			wp_reg <= 1'b0;
			rp_reg <= 1'b0;
			cnt_reg <= 2'h0;
		end else begin
			mem_reg <= mem_next;
			wp_reg <= wp_next;
			rp_reg <= rp_next;
			cnt_reg <= cnt_next;
		end
	end
	assign in_s.ready = (cnt_reg != 2'h2);
	assign out_valid  = (cnt_reg != 2'h0);
	assign out_data   = mem_reg[rp_reg];
	// ==========================================
	skid_count_a: assert property (@(posedge clk) disable iff (rst)
		cnt_reg <= 2'h2) else $error("buffer count overflow");
endmodule : tss_skid

// >>> dv/tss_sink.sv
`timescale 1ns/10ps
// receiver of the switched stream; it stalls one cycle in three
module tss_sink (
	// clock
	input  wire logic        clk,
	// stream
	input  wire logic [15:0] data,
	input  wire logic [9:0]  slot,
	input  wire logic        valid,
	output logic             ready
);
	// ==========================================
	// state
	logic [1:0]  ph = 2'h0;   // stall phase
	logic [25:0] got[$];      // {slot, word} taken, in order
	initial ready = 1'b0;
	// take a word only where valid meets ready
	always @(posedge clk) begin
		if (valid && ready) begin
			got.push_back({slot, data});
		end
		ph <= (ph == 2'h2) ? 2'h0 : ph + 2'h1;
	end
	// ready moves just after the edge, so stalls keep the buffer full
	always @(posedge clk) begin
		#1 ready = (ph != 2'h2);
	end
endmodule : tss_sink

// >>> dv/tss_switch_bench.sv
`timescale 1ns/10ps
module tss_switch_bench;
	import tss_pkg::*;
	// ==========================================
	// drive and observe
	logic        CLK_SYS  = 1'b0;
	logic        RST      = 1'b1;
	logic [1:0]  mode     = 2'h1;
	logic        fsync    = 1'b0;
	logic [15:0] par_in   = 16'h0000;
	logic        in_valid = 1'b0;
	logic        we       = 1'b0;
	logic [1:0]  tgt      = 2'h0;
	logic [9:0]  addr     = 10'h000;
	logic [9:0]  wdata    = 10'h000;
	logic [15:0] par_out;
	logic        out_valid;
	logic        out_ready;
	logic [9:0]  out_slot;
	int          errors   = 0;
	int          n_tests  = 0;
	int          cycles   = 0;
	// serial lines stay idle; only the parallel modes are exercised
	tss_switch u_tss_switch (.CLK_SYS(CLK_SYS), .RST(RST), .MODE(mode),
		.WIDE16(1'b1), .FRAME_SYNC(fsync), .SERIAL_LINE_IN(8'h00),
		.ALT_LINE_IN(8'h00), .ALT_SEL(1'b0), .SERIAL_LINE_OUT(),
		.ALT_LINE_OUT(), .PAR_IN(par_in), .PAR_IN_VALID(in_valid),
		.PAR_OUT(par_out), .PAR_OUT_SLOT(out_slot),
		.PAR_OUT_VALID(out_valid),
		.PAR_OUT_READY(out_ready), .HOST_WE(we), .HOST_TGT(tgt),
		.HOST_ADDR(addr), .HOST_WDATA(wdata));
	tss_sink u_sink (.clk(CLK_SYS), .data(par_out), .slot(out_slot),
		.valid(out_valid), .ready(out_ready));
	// ==========================================
	// helpers
	function automatic logic [15:0] word(input int s, input logic inv);
		word = {6'h15, s[9:0]} ^ {16{inv}};
	endfunction : word
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			errors++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic conclude;
		$display("comparisons %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : conclude
	// strobe stays high across back-to-back writes
	task automatic host_wr(input logic [1:0] t, input int a, input int d);
		we = 1'b1;
		tgt = t;
		addr = a[9:0];
		wdata = d[9:0];
		@(posedge CLK_SYS);
		#1;
	endtask : host_wr
	// sync pulse, one word per slot, then idle time for readout to drain
	task automatic frame(input int n, input logic inv);
		fsync = 1'b1;
		@(posedge CLK_SYS);
		#1;
		fsync = 1'b0;
		for (int s = 0; s < n; s++) begin
			in_valid = 1'b1;
			par_in = word(s, inv);
			@(posedge CLK_SYS);
			#1;
		end
		in_valid = 1'b0;
		repeat (n) @(posedge CLK_SYS);
		#1;
	endtask : frame
	// ==========================================
	// scenario: program a permutation and tones, switch two frames
	task automatic sc_switch(input logic [1:0] m, input int n);
		logic [7:0] tone;
		int         base;
		mode = m;
		for (int i = 0; i < TONE_DEPTH; i++) host_wr(TGT_TONE, i, i * 3 + 1);
		for (int o = 0; o < n; o++) begin
			host_wr(TGT_CTRL, o, (o * 5 + 3) % n);
			host_wr(TGT_TCTRL, o, (o % 16 == 7) ? 128 + o % 64 : 0);
		end
		we = 1'b0;
		frame(n, 1'b0);
		u_sink.got.delete();
		frame(n, 1'b1);
		for (int k = 0; k < 9000 && u_sink.got.size() < n + 5; k++) begin
			@(posedge CLK_SYS);
		end
		// up to four words of the older stream may lead; the last
		// slot 0 among the first five is where the new frame starts
		base = 0;
		for (int j = 0; j < 5 && j < u_sink.got.size(); j++) begin
			if (u_sink.got[j][25:16] == 10'h000) begin
				base = j;
			end
		end
		check(16'(u_sink.got.size() >= base + n), 16'h0001);
		for (int o = 0; o < n && base + o < u_sink.got.size(); o++) begin
			tone = 8'((o % 64) * 3 + 1);
			check(16'(u_sink.got[base + o][25:16]), 16'(o));
			if (o % 16 == 7) begin
				check(u_sink.got[base + o][15:0], {8'h00, tone});
			end else begin
				check(u_sink.got[base + o][15:0],
					word((o * 5 + 3) % n, 1'b0));
			end
		end
	endtask : sc_switch
	// ==========================================
	// clock, limit and sequence
	always #4 CLK_SYS = ~CLK_SYS;
	always @(posedge CLK_SYS) begin
		cycles <= cycles + 1;
		if (cycles == 40000) begin
			errors++;
			conclude();
		end
	end
	initial begin
		repeat (10) @(posedge CLK_SYS);
		#1;
		RST = 1'b0;
		sc_switch(TSS_MODE1, 512);
		sc_switch(TSS_MODE2, 1024);
		conclude();
	end
endmodule : tss_switch_bench
